// ---- rtl/dcofll_pkg.sv ----
// constants for the oscillator loop and clock request control
// assumes one 100 MHz ref_clk and word-indexed register port
package dcofll_pkg;
    localparam int unsigned DCOFLL_CLK_MHZ = 100;
    // register indices on the plain port
    localparam logic [2:0] DCOFLL_IDX_CTL0 = 3'h0; // integrator tap/fraction
    localparam logic [2:0] DCOFLL_IDX_CTL1 = 3'h1; // range, fraction disable
    localparam logic [2:0] DCOFLL_IDX_CTL2 = 3'h2; // multiplier N, prescaler
    localparam logic [2:0] DCOFLL_IDX_CTL3 = 3'h3; // reference select/divider
    localparam logic [2:0] DCOFLL_IDX_REQ = 3'h4; // request enables, off bits
    localparam logic [2:0] DCOFLL_IDX_SYS = 3'h5; // processor status bits
    localparam logic [2:0] DCOFLL_IDX_STAT = 3'h6; // clock run status
    // integrator layout
    localparam int unsigned DCOFLL_INT_W = 13;
    localparam int unsigned DCOFLL_TAP_HI = 12;
    localparam int unsigned DCOFLL_TAP_LO = 8;
    localparam int unsigned DCOFLL_FRAC_HI = 7;
    localparam int unsigned DCOFLL_FRAC_LO = 3;
    localparam logic [12:0] DCOFLL_INT_MAX = 13'h1fff;
    localparam logic [12:0] DCOFLL_INT_ONE = 13'h0001;
    localparam logic [4:0] DCOFLL_TAP_TOP = 5'h1f;
    localparam logic [4:0] DCOFLL_FRAC_OFF = 5'h00;
    // reset values
    localparam logic [2:0] DCOFLL_RANGE_RST = 3'h2;
    localparam logic [12:0] DCOFLL_INT_RST = 13'h0000;
    localparam logic [2:0] DCOFLL_REFDIV_RST = 3'h0; // n = 1
    localparam logic [2:0] DCOFLL_PRESC_RST = 3'h1; // D = 2
    localparam logic [9:0] DCOFLL_MULT_RST = 10'h01f;
    localparam logic [2:0] DCOFLL_REFSEL_RST = 3'h0;
    // reference source codes
    localparam logic [2:0] DCOFLL_REF_XT1 = 3'h0;
    localparam logic [2:0] DCOFLL_REF_TRIM = 3'h2;
    localparam logic [2:0] DCOFLL_REF_XT2 = 3'h5;
    localparam logic [2:0] DCOFLL_REF_NONE = 3'h7;
    // divider tables: code -> divisor minus one
    localparam logic [3:0] DCOFLL_N_M1 [6] =
        '{4'h0, 4'h1, 4'h3, 4'h7, 4'hb, 4'hf};
    localparam logic [4:0] DCOFLL_D_M1 [6] =
        '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
    localparam logic [2:0] DCOFLL_DIV_CODE_MAX = 3'h5;
    localparam logic [9:0] DCOFLL_MULT_MIN = 10'h001; // N=0 acts as 1
    // loop state
    typedef enum logic [1:0] {
        DCOFLL_RUN = 2'b00,
        DCOFLL_HOLD = 2'b01,
        DCOFLL_SHUT = 2'b11
    } dcofll_mode_t;
endpackage : dcofll_pkg

// ---- rtl/dcofll_ctrl.sv ----
// oscillator loop control, modulator and system clock request gating
// oscillator and reference edges arrive as one-cycle ticks on ref_clk
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dcofll_ctrl
    import dcofll_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic osc_output_tick, // one pulse per oscillator cycle
    input wire logic osc_output_level, // oscillator level, for gating
    input wire logic crystal_one_tick,
    input wire logic trimmed_reference_tick,
    input wire logic crystal_two_tick,
    input wire logic irq_entry,
    input wire logic aux_request,
    input wire logic main_request,
    input wire logic subsystem_request,
    input wire logic watchdog_aux_request,
    input wire logic watchdog_source_ok,
    input wire logic shutdown_request,
    output logic [2:0] osc_range_select,
    output logic [4:0] osc_tap,
    output logic osc_divided_tick,
    output logic loop_reference_clock,
    output logic aux_clock_en,
    output logic main_clock_en,
    output logic subsystem_clock_en,
    output logic watchdog_use_very_low_power_clock,
    output logic shutdown_low_power
);
    // whole module state in one record
    typedef struct packed {
        logic [12:0] integ; // loop integrator
        logic [2:0] range; // oscillator range
        logic fraction_disable;
        logic [9:0] mult_n; // multiplier field N
        logic [2:0] presc; // loop prescaler code
        logic [2:0] refsel; // loop reference select
        logic [2:0] refdiv; // reference divider code
        logic aux_request_enable;
        logic main_request_enable;
        logic subsystem_request_enable;
        logic subsystem_clock_off;
        logic crystal_one_off_control;
        logic crystal_two_off_control;
        logic clockgen_bit_zero;
        logic clockgen_bit_one;
        logic processor_off;
        logic aux_oscillator_off;
        logic [3:0] ref_cnt; // reference divider count
        logic [4:0] pre_cnt; // prescaler count
        logic [9:0] fb_cnt; // feedback (N+1) count
        logic [4:0] mod_cnt; // modulation window position
        logic ref_tick; // divided reference pulse
        logic [2:0] range_o;
        logic [4:0] tap_o;
        logic div_tick_o;
        logic aux_en;
        logic main_en;
        logic sub_en;
        logic wdt_vlo;
        logic shut;
        dcofll_mode_t mode;
        logic [15:0] rdata;
    } dcofll_state_t;

    dcofll_state_t st_reg;
    dcofll_state_t st_next;

    // combinational helpers
    logic src_tick; // selected raw reference edge
    logic [3:0] n_m1; // n minus one
    logic [4:0] d_m1; // D minus one
    logic [9:0] n_eff; // N with zero promoted
    logic pre_wrap; // prescaler completes D oscillator cycles
    logic fb_wrap; // feedback completes D(N+1) cycles
    logic inc; // integrator up
    logic dec; // integrator down
    logic frozen; // loop held by clockgen bits
    logic [4:0] tap; // integrator tap
    logic [4:0] frac; // integrator fraction
    logic hi_tap; // use next-higher tap this cycle
    logic aux_want;
    logic main_want;
    logic sub_want;
    logic shut_ok;

    // integrator fields and divider lookups
    always_comb begin
        tap = st_reg.integ[DCOFLL_TAP_HI:DCOFLL_TAP_LO];
        frac = st_reg.integ[DCOFLL_FRAC_HI:DCOFLL_FRAC_LO];
        // out-of-table codes clamp to the largest divisor
        n_m1 = DCOFLL_N_M1[(st_reg.refdiv > DCOFLL_DIV_CODE_MAX) ?
            DCOFLL_DIV_CODE_MAX : st_reg.refdiv];
        d_m1 = DCOFLL_D_M1[(st_reg.presc > DCOFLL_DIV_CODE_MAX) ?
            DCOFLL_DIV_CODE_MAX : st_reg.presc];
        n_eff = (st_reg.mult_n == '0) ? DCOFLL_MULT_MIN : st_reg.mult_n;
        frozen = st_reg.clockgen_bit_zero | st_reg.clockgen_bit_one;
        // reference source pick; code 7 and unused codes give nothing
        unique case (st_reg.refsel)
            DCOFLL_REF_XT1: src_tick = crystal_one_tick;
            DCOFLL_REF_TRIM: src_tick = trimmed_reference_tick;
            DCOFLL_REF_XT2: src_tick = crystal_two_tick;
            default: src_tick = 1'b0;
        endcase
        pre_wrap = osc_output_tick && (st_reg.pre_cnt >= d_m1);
        fb_wrap = pre_wrap && (st_reg.fb_cnt >= n_eff);
        inc = st_reg.ref_tick && !frozen && (st_reg.integ != DCOFLL_INT_MAX);
        dec = fb_wrap && !frozen && (st_reg.integ != '0);
        // top tap or disable or zero fraction keep the base tap
        hi_tap = !st_reg.fraction_disable && (frac != DCOFLL_FRAC_OFF) &&
            (tap != DCOFLL_TAP_TOP) && (st_reg.mod_cnt < frac);
        // requests override the off bits only while enabled
        aux_want = !st_reg.aux_oscillator_off ||
            (st_reg.aux_request_enable && aux_request);
        main_want = !st_reg.processor_off ||
            (st_reg.main_request_enable && main_request);
        sub_want = (!st_reg.clockgen_bit_one && !st_reg.subsystem_clock_off) ||
            (st_reg.subsystem_request_enable && subsystem_request);
        // crystals must be released and no aux request pending
        shut_ok = st_reg.crystal_one_off_control &&
            st_reg.crystal_two_off_control &&
            !(st_reg.aux_request_enable && aux_request) &&
            !watchdog_aux_request;
    end

    // next state
    always_comb begin
        st_next = st_reg;
        // reference divider by n
        if (src_tick) begin
            st_next.ref_cnt = (st_reg.ref_cnt >= n_m1) ? '0 :
                st_reg.ref_cnt + 4'h1;
        end
        st_next.ref_tick = src_tick && (st_reg.ref_cnt >= n_m1);
        // prescaler by D, then feedback count by N+1
        if (osc_output_tick) begin
            st_next.pre_cnt = pre_wrap ? '0 : st_reg.pre_cnt + 5'h01;
            st_next.mod_cnt = st_reg.mod_cnt + 5'h01; // 32-cycle window
        end
        if (pre_wrap) begin
            st_next.fb_cnt = fb_wrap ? 10'h000 : st_reg.fb_cnt + 10'h001;
        end
        st_next.div_tick_o = pre_wrap;
        // integrator: both at once cancel
        if (inc && !dec) begin
            st_next.integ = st_reg.integ + DCOFLL_INT_ONE;
        end else if (dec && !inc) begin
            st_next.integ = st_reg.integ - DCOFLL_INT_ONE;
        end
        st_next.mode = st_reg.shut ? DCOFLL_SHUT :
            (frozen ? DCOFLL_HOLD : DCOFLL_RUN);
        // register writes; software may set tap while held
        if (reg_wr) begin
            unique case (reg_addr)
                DCOFLL_IDX_CTL0: st_next.integ = reg_wdata[12:0];
                DCOFLL_IDX_CTL1: begin
                    st_next.range = reg_wdata[6:4];
                    st_next.fraction_disable = reg_wdata[0];
                end
                DCOFLL_IDX_CTL2: begin
                    st_next.mult_n = reg_wdata[9:0];
                    st_next.presc = reg_wdata[14:12];
                end
                DCOFLL_IDX_CTL3: begin
                    st_next.refsel = reg_wdata[6:4];
                    st_next.refdiv = reg_wdata[2:0];
                end
                DCOFLL_IDX_REQ: begin
                    st_next.aux_request_enable = reg_wdata[0];
                    st_next.main_request_enable = reg_wdata[1];
                    st_next.subsystem_request_enable = reg_wdata[2];
                    st_next.subsystem_clock_off = reg_wdata[3];
                    st_next.crystal_one_off_control = reg_wdata[4];
                    st_next.crystal_two_off_control = reg_wdata[5];
                end
                DCOFLL_IDX_SYS: begin
                    st_next.clockgen_bit_zero = reg_wdata[0];
                    st_next.clockgen_bit_one = reg_wdata[1];
                    st_next.processor_off = reg_wdata[2];
                    st_next.aux_oscillator_off = reg_wdata[3];
                end
                default: ; // unmapped and read-only: ignored
            endcase
        end
        // interrupt entry beats a same-cycle write; bit zero kept
        if (irq_entry) begin
            st_next.clockgen_bit_one = 1'b0;
            st_next.processor_off = 1'b0;
            st_next.aux_oscillator_off = 1'b0;
        end
        // shutdown latches until reset; request refused otherwise
        if (shutdown_request && shut_ok) begin
            st_next.shut = 1'b1;
        end
        // oscillator drive; fraction adds one tap for part of window
        st_next.range_o = st_reg.range;
        st_next.tap_o = tap + {4'h0, hi_tap};
        // gating changes only while the oscillator is low; shutdown clears all enables at any level
        if (!osc_output_level) begin
            st_next.aux_en = aux_want && !st_next.shut;
            st_next.main_en = main_want && !st_next.shut;
            st_next.sub_en = sub_want && !st_next.shut;
        end
        if (st_next.shut) begin
            st_next.aux_en = 1'b0;
            st_next.main_en = 1'b0;
            st_next.sub_en = 1'b0;
        end
        st_next.wdt_vlo = !watchdog_source_ok;
        // read data stands one cycle after the strobe
        st_next.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                DCOFLL_IDX_CTL0: st_next.rdata = {3'h0, st_reg.integ};
                DCOFLL_IDX_CTL1: st_next.rdata = {9'h000, st_reg.range,
                    3'h0, st_reg.fraction_disable};
                DCOFLL_IDX_CTL2: st_next.rdata = {1'b0, st_reg.presc,
                    2'h0, st_reg.mult_n};
                DCOFLL_IDX_CTL3: st_next.rdata = {9'h000, st_reg.refsel,
                    1'b0, st_reg.refdiv};
                DCOFLL_IDX_REQ: st_next.rdata = {10'h000,
                    st_reg.crystal_two_off_control,
                    st_reg.crystal_one_off_control,
                    st_reg.subsystem_clock_off,
                    st_reg.subsystem_request_enable,
                    st_reg.main_request_enable, st_reg.aux_request_enable};
                DCOFLL_IDX_SYS: st_next.rdata = {12'h000,
                    st_reg.aux_oscillator_off, st_reg.processor_off,
                    st_reg.clockgen_bit_one, st_reg.clockgen_bit_zero};
                DCOFLL_IDX_STAT: st_next.rdata = {8'h00, st_reg.mode,
                    st_reg.shut, st_reg.wdt_vlo, 1'b0, st_reg.sub_en,
                    st_reg.main_en, st_reg.aux_en};
                default: st_next.rdata = 16'h0000; // unmapped reads zero
            endcase
        end
    end

    // state register; reset gives range 2, tap 0, D 2, n 1
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.integ <= DCOFLL_INT_RST;
            st_reg.range <= DCOFLL_RANGE_RST;
            st_reg.range_o <= DCOFLL_RANGE_RST;
            st_reg.mult_n <= DCOFLL_MULT_RST;
            st_reg.presc <= DCOFLL_PRESC_RST;
            st_reg.refdiv <= DCOFLL_REFDIV_RST;
            st_reg.refsel <= DCOFLL_REFSEL_RST;
            st_reg.aux_request_enable <= 1'b1;
            st_reg.main_request_enable <= 1'b1;
            st_reg.subsystem_request_enable <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the record
    assign reg_rdata = st_reg.rdata;
    assign osc_range_select = st_reg.range_o;
    assign osc_tap = st_reg.tap_o;
    assign osc_divided_tick = st_reg.div_tick_o;
    assign loop_reference_clock = st_reg.ref_tick;
    assign aux_clock_en = st_reg.aux_en;
    assign main_clock_en = st_reg.main_en;
    assign subsystem_clock_en = st_reg.sub_en;
    assign watchdog_use_very_low_power_clock = st_reg.wdt_vlo;
    assign shutdown_low_power = st_reg.shut;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ref_div_bound;
        loop_reference_clock && n_m1 != '0 |=> !loop_reference_clock;
    endproperty
    a_ref_div_bound: assert property (p_ref_div_bound)
        else $error("reference pulses closer than divider");
    property p_no_ref;
        (st_reg.refsel == DCOFLL_REF_NONE) [*2] |-> !loop_reference_clock;
    endproperty
    a_no_ref: assert property (p_no_ref)
        else $error("reference produced with select 7");
    property p_dec_on_wrap;
        !frozen && !inc && !reg_wr && st_reg.integ != '0 && fb_wrap
            |=> st_reg.integ == $past(st_reg.integ) - DCOFLL_INT_ONE;
    endproperty
    a_dec_on_wrap: assert property (p_dec_on_wrap)
        else $error("integrator missed a decrement");
    property p_frozen;
        frozen && !reg_wr |=> $stable(st_reg.integ);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("integrator moved while held");
    property p_top_tap;
        tap == DCOFLL_TAP_TOP |=> osc_tap == DCOFLL_TAP_TOP;
    endproperty
    a_top_tap: assert property (p_top_tap)
        else $error("tap left 31");
    property p_mod_off;
        st_reg.fraction_disable || frac == DCOFLL_FRAC_OFF |=> osc_tap == $past(tap);
    endproperty
    a_mod_off: assert property (p_mod_off)
        else $error("modulation active while off");
    property p_aux_req;
        st_reg.aux_request_enable && aux_request && !st_reg.shut &&
            !osc_output_level ##1 !st_reg.shut |-> aux_clock_en;
    endproperty
    a_aux_req: assert property (p_aux_req)
        else $error("aux request not honoured");
    property p_shut_all_off;
        shutdown_low_power |-> !aux_clock_en && !main_clock_en &&
            !subsystem_clock_en;
    endproperty
    a_shut_all_off: assert property (p_shut_all_off)
        else $error("clock running in shutdown");
    property p_shut_block;
        !st_reg.shut && shutdown_request && st_reg.aux_request_enable &&
            aux_request |=> !shutdown_low_power;
    endproperty
    a_shut_block: assert property (p_shut_block)
        else $error("shutdown entered under aux request");
    property p_irq;
        irq_entry |=> !st_reg.clockgen_bit_one && !st_reg.processor_off &&
            !st_reg.aux_oscillator_off && st_reg.clockgen_bit_zero == $past(
            (reg_wr && reg_addr == DCOFLL_IDX_SYS) ? reg_wdata[0] :
            st_reg.clockgen_bit_zero);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt entry handled wrongly");

    c_lock_step: cover property (inc ##[1:50] dec);
    c_mod_hi: cover property (hi_tap ##1 osc_tap == tap + 5'h01);
    c_shut: cover property (shutdown_request ##1 shutdown_low_power);
endmodule : dcofll_ctrl

`default_nettype wire

// ---- verification/dcofll_partner_model.sv ----
// partner: oscillator and reference edge source for the loop control
// assumes the bench raises the enables right after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module dcofll_partner_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_en,
    input wire logic ref_en,
    output logic osc_output_tick,
    output var logic osc_output_level,
    output logic crystal_one_tick,
    output logic trimmed_reference_tick,
    output logic crystal_two_tick
);
    // level toggles freely so gating always meets a low phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_output_level <= 1'b0;
        end else begin
            osc_output_level <= ~osc_output_level;
        end
    end
    // one tick per enabled cycle; select in the block picks a source
    assign osc_output_tick = osc_en;
    assign crystal_one_tick = ref_en;
    assign trimmed_reference_tick = ref_en;
    assign crystal_two_tick = ref_en;
endmodule : dcofll_partner_model
`default_nettype wire

// ---- verification/dcofll_ctrl_tb.sv ----
// self-checking bench for the oscillator loop and clock request control
// assumes the partner model supplies oscillator and reference ticks
`timescale 1ns/1ps
`default_nettype none
module dcofll_ctrl_tb;
    import dcofll_pkg::*;
    typedef struct packed {logic [15:0] e; logic [15:0] m;} dcofll_exp_t;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
    logic osc_en = 1'b0, ref_en = 1'b0, irq = 1'b0, shreq = 1'b0;
    logic areq = 1'b0, mreq = 1'b0, sreq = 1'b0, wreq = 1'b0, wok = 1'b1;
    logic otick, olvl, t1, t2, t3, divt, lref, aen, men, sen, wvlo, shut;
    logic [2:0] range;
    logic [4:0] tap;
    logic pend = 1'b0; // read issued last cycle
    dcofll_exp_t exp_q[$]; // expected read data, oldest first
    dcofll_exp_t x;
    int n_fail = 0, check_count = 0, cnt, i;
    // modulator cases: integrator, range word, cycles off base tap
    logic [15:0] m_int [4] = '{16'h0328, 16'h0328, 16'h1f28, 16'h0300};
    logic [15:0] m_ctl [4] = '{16'h0050, 16'h0051, 16'h0050, 16'h0050};
    int m_exp [4] = '{5, 0, 0, 0};
    // shutdown cases: request word, aux req, watchdog req, expected
    logic [15:0] s_req [4] = '{16'h001f, 16'h003f, 16'h003f, 16'h003f};
    logic [3:0] s_tab [4] = '{4'b0000, 4'b0100, 4'b0010, 4'b0001};
    logic [2:0] refsel [3] = '{DCOFLL_REF_XT1, DCOFLL_REF_TRIM, DCOFLL_REF_XT2};

    dcofll_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_output_tick(otick),
        .osc_output_level(olvl), .crystal_one_tick(t1),
        .trimmed_reference_tick(t2), .crystal_two_tick(t3),
        .irq_entry(irq), .aux_request(areq), .main_request(mreq),
        .subsystem_request(sreq), .watchdog_aux_request(wreq),
        .watchdog_source_ok(wok), .shutdown_request(shreq),
        .osc_range_select(range), .osc_tap(tap), .osc_divided_tick(divt),
        .loop_reference_clock(lref), .aux_clock_en(aen),
        .main_clock_en(men), .subsystem_clock_en(sen),
        .watchdog_use_very_low_power_clock(wvlo),
        .shutdown_low_power(shut));
    dcofll_partner_model i_partner (.ref_clk(ref_clk), .rst(rst),
        .osc_en(osc_en), .ref_en(ref_en), .osc_output_tick(otick),
        .osc_output_level(olvl), .crystal_one_tick(t1),
        .trimmed_reference_tick(t2), .crystal_two_tick(t3));

    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // compare and count; case equality keeps unknowns failing
    task automatic chk(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // one-cycle read strobe; expectation noted for the monitor
    task automatic rd(input logic [2:0] a, input logic [15:0] e,
            input logic [15:0] m);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back('{e: e, m: m});
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd
    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (pend) begin
            x = exp_q.pop_front();
            chk("reg_rdata", x.e & x.m, reg_rdata & x.m);
        end
        pend <= reg_rd;
    end
    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    // watchdog; whole run is under a thousand cycles
    initial begin
        #100us;
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h246edb97));
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        // reset state of registers and ports
        chk("range", 16'h0002, 16'(range));
        chk("tap", 16'h0000, 16'(tap));
        rd(DCOFLL_IDX_CTL1, 16'h0020, 16'h0071);
        rd(DCOFLL_IDX_CTL2, 16'h101f, 16'h73ff);
        rd(DCOFLL_IDX_CTL3, 16'h0000, 16'h0077);
        rd(DCOFLL_IDX_REQ, 16'h0007, 16'h0007);
        rd(3'h7, 16'h0000, 16'hffff);
        rd(DCOFLL_IDX_STAT, 16'h0007, 16'h0037);
        // divided tick: 2*D oscillator ticks give two pulses per code
        for (int c = 0; c < 6; c++) begin
            wr(DCOFLL_IDX_CTL2, {1'b0, 3'(c), 12'h01f});
            cnt = 0;
            osc_en <= 1'b1;
            for (i = 0; i < 2 * (int'(DCOFLL_D_M1[c]) + 1) + 3; i++) begin
                @(posedge ref_clk);
                cnt += int'(divt);
                if (i == 2 * int'(DCOFLL_D_M1[c]) + 1) osc_en <= 1'b0;
            end
            chk("osc_divided_tick", 16'h0002, 16'(cnt));
            cyc(4);
        end
        // frozen loop: software owns the integrator
        wr(DCOFLL_IDX_SYS, 16'h0001);
        repeat (4) begin
            v = 16'($urandom() & 32'h1fff);
            wr(DCOFLL_IDX_CTL0, v);
            rd(DCOFLL_IDX_CTL0, v, 16'h1fff);
        end
        for (int k = 0; k < 4; k++) begin
            wr(DCOFLL_IDX_CTL0, m_int[k]);
            wr(DCOFLL_IDX_CTL1, m_ctl[k]);
            osc_en <= 1'b1;
            cyc(40);
            cnt = 0;
            repeat (32) begin
                @(posedge ref_clk);
                cnt += int'(tap !== m_int[k][12:8]);
            end
            osc_en <= 1'b0;
            chk("fraction", 16'(m_exp[k]), 16'(cnt));
            chk("range", 16'h0005, 16'(range));
        end
        // integrator up on references, down on feedback (D=1, N=0)
        wr(DCOFLL_IDX_CTL0, 16'h0100);
        wr(DCOFLL_IDX_CTL2, 16'h0000);
        wr(DCOFLL_IDX_SYS, 16'h0000);
        ref_en <= 1'b1;
        cyc(6);
        ref_en <= 1'b0;
        cyc(4);
        rd(DCOFLL_IDX_CTL0, 16'h0106, 16'h1fff);
        wr(DCOFLL_IDX_CTL3, 16'h0070);
        osc_en <= 1'b1;
        cyc(10);
        osc_en <= 1'b0;
        cyc(4);
        rd(DCOFLL_IDX_CTL0, 16'h0101, 16'h1fff);
        wr(DCOFLL_IDX_SYS, 16'h0002);
        osc_en <= 1'b1;
        cyc(10);
        osc_en <= 1'b0;
        cyc(4);
        rd(DCOFLL_IDX_CTL0, 16'h0101, 16'h1fff);
        // reference divider: spacing of loop reference pulses is n
        ref_en <= 1'b1;
        for (int c = 0; c < 6; c++) begin
            wr(DCOFLL_IDX_CTL3, {9'h000, refsel[c % 3], 1'b0, 3'(c)});
            repeat (3) begin
                i = 0;
                do begin
                    @(posedge ref_clk);
                    i++;
                end while (lref !== 1'b1 && i < 40);
            end
            chk("ref spacing", 16'(DCOFLL_N_M1[c]) + 16'h0001, 16'(i));
        end
        wr(DCOFLL_IDX_CTL3, 16'h0070);
        cyc(2);
        cnt = 0;
        repeat (40) begin
            @(posedge ref_clk);
            cnt += int'(lref);
        end
        ref_en <= 1'b0;
        chk("no reference", 16'h0000, 16'(cnt));
        // low-power gating and peripheral requests
        wr(DCOFLL_IDX_SYS, 16'h000f);
        cyc(4);
        rd(DCOFLL_IDX_STAT, 16'h0000, 16'h0037);
        areq <= 1'b1;
        mreq <= 1'b1;
        sreq <= 1'b1;
        cyc(4);
        rd(DCOFLL_IDX_STAT, 16'h0007, 16'h0037);
        rd(DCOFLL_IDX_SYS, 16'h000f, 16'h000f);
        wr(DCOFLL_IDX_REQ, 16'h0000);
        cyc(4);
        rd(DCOFLL_IDX_STAT, 16'h0000, 16'h0037);
        wr(DCOFLL_IDX_REQ, 16'h0007);
        irq <= 1'b1;
        areq <= 1'b0;
        mreq <= 1'b0;
        sreq <= 1'b0;
        cyc(1);
        irq <= 1'b0;
        cyc(4);
        rd(DCOFLL_IDX_SYS, 16'h0001, 16'h000f);
        rd(DCOFLL_IDX_STAT, 16'h0007, 16'h0037);
        wr(DCOFLL_IDX_REQ, 16'h000f);
        cyc(4);
        rd(DCOFLL_IDX_STAT, 16'h0003, 16'h0037);
        chk("clock enables", 16'h0003, 16'({sen, men, aen}));
        // watchdog falls back when its source is missing
        wok <= 1'b0;
        cyc(3);
        chk("watchdog clock", 16'h0001, 16'(wvlo));
        wok <= 1'b1;
        // shutdown refused while blocked; last case enters, sticky
        for (int k = 0; k < 4; k++) begin
            wr(DCOFLL_IDX_REQ, s_req[k]);
            areq <= s_tab[k][2];
            wreq <= s_tab[k][1];
            cyc(3);
            shreq <= 1'b1;
            cyc(1);
            shreq <= 1'b0;
            cyc(4);
            chk("shutdown", 16'(s_tab[k][0]), 16'(shut));
        end
        rd(DCOFLL_IDX_STAT, 16'h0020, 16'h0037);
        cyc(4);
        complete_run();
    end
endmodule : dcofll_ctrl_tb
`default_nettype wire
